/* inc/urs_pkg.sv */
// Functional notes
// - Each channel holds two resume and two pause flow-control characters, read/write.
// - Power-up loads divisor high byte with 0x00 and low byte with 0x01.
// - The reset pin leaves both divisor bytes untouched.
// - On reset modem status low nibble clears; high nibble shows inverted modem inputs.
// - Intel-style bus: interrupt pin is released (not driven) during reset.
// - Motorola-style bus: active-low interrupt pin driven high during reset.
// - Channel B logic-level serial output is driven high during reset.
// - Both channels get identical, independent reset values.
// - Host bus offers Intel-style or Motorola-style signalling mode.
`default_nettype none
package urs_pkg;
  localparam int CHAN_NUM = 2;
  localparam int REG_NUM = 16;
  localparam int IDX_W = 4;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int IDX_LSB = 2;
  localparam int CHAN_BIT = 6;
  localparam int TOP_LSB = 7;

  // Register indices; byte address is chan*0x40 + index*4
  localparam logic [3:0] IDX_DIV_LOW = 4'h0;
  localparam logic [3:0] IDX_DIV_HIGH = 4'h1;
  localparam logic [3:0] IDX_IER = 4'h2;
  localparam logic [3:0] IDX_FCR = 4'h3;
  localparam logic [3:0] IDX_LCR = 4'h4;
  localparam logic [3:0] IDX_MCR = 4'h5;
  localparam logic [3:0] IDX_SPR = 4'h6;
  localparam logic [3:0] IDX_EFR = 4'h7;
  localparam logic [3:0] IDX_FCTR = 4'h8;
  localparam logic [3:0] IDX_DIV_FRAC = 4'h9;
  localparam logic [3:0] IDX_RESUME_ONE = 4'ha;
  localparam logic [3:0] IDX_RESUME_TWO = 4'hb;
  localparam logic [3:0] IDX_PAUSE_ONE = 4'hc;
  localparam logic [3:0] IDX_PAUSE_TWO = 4'hd;
  localparam logic [3:0] IDX_MSR = 4'he;
  localparam logic [3:0] IDX_ISR = 4'hf;
  localparam logic [3:0] RW_LAST = 4'hd;

  // Reset values
  localparam logic [7:0] RST_DIV_LOW = 8'h01;
  localparam logic [7:0] RST_DIV_HIGH = 8'h00;
  localparam logic [7:0] RST_SPR = 8'hff;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] ISR_NONE = 8'h01;
  localparam logic [7:0] ISR_MODEM = 8'h00;

  // Field positions
  localparam int IER_MODEM_BIT = 3;
  localparam int LCR_BREAK_BIT = 6;

  typedef struct packed {
    logic en;
    logic [IDX_W-1:0] idx;
    logic [7:0] data;
  } urs_wr_t;

  // Modem pins, active low; order matches status bits 7..4
  typedef struct packed {
    logic cd_n;
    logic ri_n;
    logic dsr_n;
    logic cts_n;
  } urs_modem_t;

  function automatic logic [7:0] urs_rst_val(input logic [IDX_W-1:0] idx);
    logic [7:0] v;
    v = RST_ZERO;
    case (idx)
      IDX_DIV_LOW: v = RST_DIV_LOW;
      IDX_DIV_HIGH: v = RST_DIV_HIGH;
      IDX_SPR: v = RST_SPR;
      default: v = RST_ZERO;
    endcase
    return v;
  endfunction : urs_rst_val
endpackage : urs_pkg
`default_nettype wire

/* design/urs_chan_regs.sv */
`timescale 1ns/10ps
`default_nettype none
module urs_chan_regs
  import urs_pkg::*;
(
  // Clock and power-up reset
  input wire logic pclk,
  input wire logic presetn,
  // Reset pin, synchronous clear
  input wire logic soft_clr,
  // Register access
  input wire urs_wr_t wr,
  input wire logic [IDX_W-1:0] rd_idx,
  input wire logic [3:0] msr_clr,
  output logic [7:0] rd_data,
  // Modem inputs
  input wire urs_modem_t modem_n,
  // Status to top
  output logic int_req_q,
  output logic break_req
);
  logic [RW_LAST:0][7:0] rw_q;
  logic [3:0] level_q;
  logic [3:0] delta_q;
  logic [3:0] delta_d;
  logic primed_q;
  logic [3:0] level_now;

  assign level_now = ~modem_n;

  genvar g;
  for (g = 0; g <= RW_LAST; g++) begin : g_reg
    if (g == IDX_DIV_LOW || g == IDX_DIV_HIGH) begin : g_div
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          rw_q[g] <= urs_rst_val(IDX_W'(g));
        end else if (wr.en && wr.idx == IDX_W'(g)) begin
          rw_q[g] <= wr.data;
        end
      end
    end else begin : g_std
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          rw_q[g] <= urs_rst_val(IDX_W'(g));
        end else if (soft_clr) begin
          rw_q[g] <= urs_rst_val(IDX_W'(g));
        end else if (wr.en && wr.idx == IDX_W'(g)) begin
          rw_q[g] <= wr.data;
        end
      end
    end
  end

  // Modem level tracking, live even under the reset pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_q <= 4'h0;
    end else begin
      level_q <= level_now;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      primed_q <= 1'b0;
    end else begin
      primed_q <= ~soft_clr;
    end
  end

  // Change flags, a new change wins over a read clear
  always_comb begin
    delta_d = delta_q & ~msr_clr;
    if (primed_q) begin
      delta_d = delta_d | (level_q ^ level_now);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      delta_q <= 4'h0;
    end else if (soft_clr) begin
      delta_q <= 4'h0;
    end else begin
      delta_q <= delta_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_req_q <= 1'b0;
    end else if (soft_clr) begin
      int_req_q <= 1'b0;
    end else begin
      int_req_q <= rw_q[IDX_IER][IER_MODEM_BIT] & (|delta_q);
    end
  end

  assign break_req = rw_q[IDX_LCR][LCR_BREAK_BIT];

  always_comb begin
    rd_data = RST_ZERO;
    case (rd_idx)
      IDX_MSR: rd_data = {level_q, delta_q};
      IDX_ISR: rd_data = int_req_q ? ISR_MODEM : ISR_NONE;
      default: rd_data = rw_q[rd_idx];
    endcase
  end
endmodule : urs_chan_regs
`default_nettype wire

/* design/urs_top.sv */
`timescale 1ns/10ps
`default_nettype none
module urs_top
  import urs_pkg::*;
#(
  parameter int CHANS = CHAN_NUM
) (
  // Clock and power-up reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Device reset pin and bus mode strap
  input wire logic device_reset,
  input wire logic bus_mode_moto,
  // Modem inputs per channel
  input wire urs_modem_t modem_n [CHANS],
  // Interrupt pin per channel
  output logic int_irq_o [CHANS],
  output logic int_irq_oe [CHANS],
  // Channel B serial output
  output logic serial_out_chan_b_logic
);
  localparam int CHAN_B = CHANS - 1;

  if (CHANS != CHAN_NUM) begin : g_chk
    $error("urs_top: CHANS must be 2");
  end
  if (IDX_LSB + IDX_W > CHAN_BIT) begin : g_chk_idx
    $error("urs_top: index field runs into the channel bit");
  end
  if (CHAN_BIT >= TOP_LSB || TOP_LSB >= ADDR_W) begin : g_chk_map
    $error("urs_top: channel bit or upper field outside the address");
  end
  if (DATA_W < 8) begin : g_chk_data
    $error("urs_top: data bus narrower than one register");
  end
  if (RW_LAST >= IDX_MSR || IDX_MSR >= IDX_ISR) begin : g_chk_ro
    $error("urs_top: writable range reaches the status registers");
  end
  if (REG_NUM != (1 << IDX_W)) begin : g_chk_regs
    $error("urs_top: register count does not match the index width");
  end
  if (IER_MODEM_BIT >= 8 || LCR_BREAK_BIT >= 8) begin : g_chk_bits
    $error("urs_top: control bit outside a register byte");
  end
  if ({RST_DIV_HIGH, RST_DIV_LOW} == '0) begin : g_chk_div
    $error("urs_top: power-up divisor of zero cannot serve");
  end

  // Bus decode
  logic setup;
  logic access;
  logic mis_align;
  logic out_of_map;
  logic ro_write;
  logic addr_ok;
  logic ro_hit;
  logic err;
  logic wr_ok;
  logic [IDX_W-1:0] idx;
  logic chan_sel;
  logic [DATA_W-1:0] rd_word;
  logic [DATA_W-1:0] prdata_q;

  // Reset and mode state
  logic rst_hold_q;
  logic strap_done_q;
  logic moto_q;
  logic mode_moto;
  logic serial_b_d;
  logic serial_b_q;

  // Per-channel results
  logic [7:0] rd_data [CHANS];
  logic int_req [CHANS];
  logic break_req [CHANS];

  // Address decode
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign idx = paddr[IDX_LSB +: IDX_W];
  assign chan_sel = paddr[CHAN_BIT];
  assign mis_align = paddr[IDX_LSB-1:0] != '0;
  assign out_of_map = paddr[ADDR_W-1:TOP_LSB] != '0;
  assign ro_hit = idx > RW_LAST;
  assign ro_write = pwrite & ro_hit;
  assign addr_ok = ~mis_align & ~out_of_map;
  assign err = mis_align | out_of_map | ro_write;
  assign wr_ok = access & addr_ok & pwrite & ~ro_hit & pstrb[0] & ~device_reset;

  assign pready = 1'b1;
  assign pslverr = access & err;
  assign prdata = prdata_q;

  // Selected channel byte on the low lane, zero on a bad address
  always_comb begin
    rd_word = '0;
    if (!pwrite && addr_ok) begin
      rd_word[7:0] = rd_data[chan_sel];
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
    end else if (setup) begin
      prdata_q <= rd_word;
    end
  end

  // Per-channel register sets
  for (genvar c = 0; c < CHANS; c++) begin : g_chan
    urs_wr_t wr;
    logic chan_hit;
    logic hit;
    logic irq_act;
    logic [3:0] msr_clr;

    // Write and status-clear strobes
    assign chan_hit = chan_sel == 1'(c);
    assign hit = access & addr_ok & chan_hit;
    assign wr.en = wr_ok & chan_hit;
    assign wr.idx = idx;
    assign wr.data = pwdata[7:0];
    assign msr_clr = (hit && !pwrite && idx == IDX_MSR) ? prdata_q[3:0] : 4'h0;

    urs_chan_regs u_regs (
      .pclk(pclk),
      .presetn(presetn),
      .soft_clr(device_reset),
      .wr(wr),
      .rd_idx(idx),
      .msr_clr(msr_clr),
      .rd_data(rd_data[c]),
      .modem_n(modem_n[c]),
      .int_req_q(int_req[c]),
      .break_req(break_req[c])
    );

    // Interrupt pin drive by bus mode
    assign irq_act = int_req[c] & ~rst_hold_q;
    always_comb begin
      int_irq_oe[c] = 1'b1;
      int_irq_o[c] = 1'b0;
      case (mode_moto)
        1'b1: begin
          int_irq_o[c] = rst_hold_q | ~int_req[c];
        end
        1'b0: begin
          int_irq_oe[c] = ~rst_hold_q;
          int_irq_o[c] = irq_act;
        end
        default: begin
          int_irq_oe[c] = 1'b0;
        end
      endcase
    end
  end

  // Reset state seen by the pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_hold_q <= 1'b1;
    end else begin
      rst_hold_q <= device_reset;
    end
  end

  // Bus mode strap, caught after each reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_done_q <= 1'b0;
    end else begin
      strap_done_q <= ~device_reset;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      moto_q <= 1'b0;
    end else if (!strap_done_q) begin
      moto_q <= bus_mode_moto;
    end
  end

  // Bus mode in force, strap pin until caught
  always_comb begin
    if (strap_done_q) begin
      mode_moto = moto_q;
    end else begin
      mode_moto = bus_mode_moto;
    end
  end

  // Channel B serial output, idle high
  always_comb begin
    serial_b_d = ~break_req[CHAN_B];
    if (device_reset) begin
      serial_b_d = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_b_q <= 1'b1;
    end else begin
      serial_b_q <= serial_b_d;
    end
  end

  assign serial_out_chan_b_logic = serial_b_q;
endmodule : urs_top
`default_nettype wire

/* tb/urs_properties.sv */
`timescale 1ns/10ps
`default_nettype none
module urs_properties
  import urs_pkg::*;
#(
  parameter int CHANS = CHAN_NUM
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins
  input wire logic device_reset,
  input wire logic bus_mode_moto,
  input wire urs_modem_t modem_n [CHANS],
  input wire logic int_irq_o [CHANS],
  input wire logic int_irq_oe [CHANS],
  input wire logic serial_out_chan_b_logic
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  assign acc = psel && penable;
  property p_ready; acc |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_txb; $past(device_reset) |-> serial_out_chan_b_logic; endproperty
  a_txb: assert property (p_txb) else $error("serial out low in reset");
  property p_tri; !bus_mode_moto && $past(device_reset) |-> !int_irq_oe[0] && !int_irq_oe[1];
  endproperty
  a_tri: assert property (p_tri) else $error("irq driven in reset");
  property p_moto;
    bus_mode_moto && $past(device_reset) |-> int_irq_oe[0] && int_irq_o[0] && int_irq_oe[1] && int_irq_o[1];
  endproperty
  a_moto: assert property (p_moto) else $error("irq not high in reset");
  property p_drive; !bus_mode_moto && $past(presetn) && !$past(device_reset) |-> int_irq_oe[0];
  endproperty
  a_drive: assert property (p_drive) else $error("irq released");
  property p_ro; acc && pwrite && paddr[5:2] == IDX_MSR |-> pslverr; endproperty
  a_ro: assert property (p_ro) else $error("status write taken");
  property p_map; acc && paddr[11:7] != 5'h0 |-> pslverr; endproperty
  a_map: assert property (p_map) else $error("unmapped accepted");
  property p_hi; acc |-> prdata[31:8] == 24'h0; endproperty
  a_hi: assert property (p_hi) else $error("upper data set");
  property p_msr;
    acc && !pwrite && paddr == 12'h038 && $stable(modem_n[0]) && $past(modem_n[0]) == $past(modem_n[0], 2)
      |-> prdata[7:4] == ~modem_n[0];
  endproperty
  a_msr: assert property (p_msr) else $error("modem levels wrong");
  c_dev: cover property (device_reset ##1 !device_reset);
  c_err: cover property (acc && pslverr);
  c_irq: cover property (!bus_mode_moto && int_irq_oe[0] && int_irq_o[0]);
endmodule : urs_properties
bind urs_top urs_properties #(.CHANS(CHANS)) u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .device_reset(device_reset), .bus_mode_moto(bus_mode_moto),
  .modem_n(modem_n), .int_irq_o(int_irq_o), .int_irq_oe(int_irq_oe),
  .serial_out_chan_b_logic(serial_out_chan_b_logic));
`default_nettype wire

/* tb/urs_host.sv */
`timescale 1ns/10ps
`default_nettype none
module urs_host
  import urs_pkg::*;
(
  // Clock
  input wire logic pclk,
  // APB master
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [ADDR_W-1:0] paddr,
  output logic [DATA_W-1:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hf;
  end
  // One transfer, setup then access until ready
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
      output logic [DATA_W-1:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    if (pready !== 1'b1) begin
      urs_register_reset_state_tb.n_fail++;
      urs_register_reset_state_tb.final_report();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : urs_host
`default_nettype wire

/* tb/urs_register_reset_state_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module urs_register_reset_state_tb
  import urs_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic device_reset = 1'b0;
  logic bus_mode_moto = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, er, serial_out_chan_b_logic;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd, d;
  logic [3:0] pstrb;
  urs_modem_t modem_n [2];
  logic int_irq_o [2];
  logic int_irq_oe [2];
  logic [31:0] lfsr_q = 32'hb3fe;
  logic [7:0] sh [2][16];
  logic [11:0] bad [4] = '{12'h038, 12'h07c, 12'h080, 12'h002};
  int n_fail = 0;
  int cmp_count = 0;
  always #10 pclk = ~pclk;
  urs_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .device_reset(device_reset), .bus_mode_moto(bus_mode_moto),
    .modem_n(modem_n), .int_irq_o(int_irq_o), .int_irq_oe(int_irq_oe),
    .serial_out_chan_b_logic(serial_out_chan_b_logic));
  urs_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic final_report();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report
  // Expected reset state, divisors kept on the reset pin
  task automatic fill(input logic keep);
    for (int c = 0; c < 2; c++) begin
      for (int i = 0; i < 16; i++) begin
        if (!keep || i > 1) sh[c][i] = 8'h00;
      end
      if (!keep) sh[c][0] = 8'h01;
      sh[c][6] = 8'hff;
      sh[c][14] = {~4'(modem_n[c]), 4'h0};
      sh[c][15] = 8'h01;
    end
  endtask : fill
  task automatic rd_all();
    for (int c = 0; c < 2; c++) begin
      for (int i = 0; i < 16; i++) begin
        host.xfer(1'b0, 12'(c * 64 + i * 4), 32'h0, rd, er);
        chk("reg", rd, {24'h0, sh[c][i]});
        chk("err", {31'h0, er}, 32'h0);
      end
    end
  endtask : rd_all
  initial begin
    modem_n[0] = urs_modem_t'(4'ha);
    modem_n[1] = urs_modem_t'(4'h5);
    for (int m = 0; m < 2; m++) begin
      presetn <= 1'b0;
      bus_mode_moto <= 1'(m);
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      fill(1'b0);
      rd_all();
      for (int c = 0; c < 2; c++) begin
        for (int i = 0; i <= 13; i++) begin
          lfsr_q = nxt(lfsr_q);
          d = lfsr_q;
          if (i == 2) d[3] = (c == 0);
          host.xfer(1'b1, 12'(c * 64 + i * 4), d, rd, er);
          sh[c][i] = d[7:0];
        end
      end
      for (int j = 0; j < 4; j++) begin
        host.xfer(1'b1, bad[j], lfsr_q, rd, er);
        chk("bad wr", {31'h0, er}, 32'h1);
      end
      host.xfer(1'b0, 12'h080, 32'h0, rd, er);
      chk("bad rd", {rd[30:0], er}, 32'h1);
      host.pstrb <= 4'h0;
      host.xfer(1'b1, 12'h018, ~{24'h0, sh[0][6]}, rd, er);
      host.pstrb <= 4'hf;
      chk("strb err", {31'h0, er}, 32'h0);
      chk("txb run", {31'h0, serial_out_chan_b_logic}, {31'h0, ~sh[1][4][6]});
      rd_all();
      @(posedge pclk);
      modem_n[0] <= urs_modem_t'(4'(modem_n[0]) ^ 4'h1);
      modem_n[1] <= urs_modem_t'(4'(modem_n[1]) ^ 4'h8);
      repeat (3) @(posedge pclk);
      #1;
      for (int c = 0; c < 2; c++) begin
        chk("irq", {31'h0, int_irq_o[c]}, {31'h0, sh[c][2][3] ^ 1'(m)});
        chk("irq oe", {31'h0, int_irq_oe[c]}, 32'h1);
      end
      @(posedge pclk);
      device_reset <= 1'b1;
      repeat (3) @(posedge pclk);
      #1;
      chk("txb", {31'h0, serial_out_chan_b_logic}, 32'h1);
      for (int c = 0; c < 2; c++) begin
        chk("irq oe", {31'h0, int_irq_oe[c]}, 32'(m));
        if (m == 1) chk("irq", {31'h0, int_irq_o[c]}, 32'h1);
      end
      @(posedge pclk);
      device_reset <= 1'b0;
      fill(1'b1);
      rd_all();
    end
    final_report();
  end
endmodule : urs_register_reset_state_tb
`default_nettype wire
